// [logic/tsrs_bank.sv]
// Register bank, selection logic and limit compare of the sensor
//
// Contract
// - Temperature result is read-only; bus writes never alter it.
// - Result double-buffered; readable copy reloads once per conversion period.
// - Upper and lower alert limits are readable and writable.
// - Alert asserts when temperature leaves the upper/lower window.
// - Separate critical limit register gives a further threshold.
// - Configuration register sets up selectable features.
// - Manufacturer and device identification registers are readable.
// - Register selection is 8-bit, write-only, never read back.
// - Only low four selection bits decode; master writes upper bits zero.
// - Last written selection is kept for later reads.
// - No auto-increment; each register selected explicitly.
`timescale 1ns/10ps
`default_nettype none

module tsrs_bank
   import tsrs_pkg::*;
#(
   parameter int          CONV_CYCLES = TSRS_CONV_CYCLES,
   parameter logic [15:0] MFR_ID      = 16'h00A5, // Arbitrary value
   parameter logic [15:0] DEV_ID      = 16'h005A  // Arbitrary value
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   // Transaction framing from the serial front end
   input  wire logic             xfer_start_in,
   input  wire logic             xfer_read_in,
   // Byte written by the master
   input  wire tsrs_byte_t       wr_byte_in,
   // Byte requested by the master
   input  wire logic             rd_req_in,
   output logic      [7:0]       rd_data_out,
   output logic                  rd_valid_out,
   // Converter result
   input  wire logic             sample_valid_in,
   input  wire logic [15:0]      sample_in,
   // Threshold outputs and reload pulse
   output logic                  alert_out,
   output logic                  crit_out,
   output logic                  update_out
);

   // ==================================================================
   // State
   logic [7:0]      register_select;
   logic [15:0]     temp_shadow;
   logic [15:0]     temp_result;
   logic [31:0]     conv_count;
   logic [7:0]      high_byte;
   logic            rd_low;
   tsrs_wr_state_t  wr_state;
   tsrs_wr_state_t  next_wr_state;

   // ==================================================================
   // Decode
   wire logic [3:0]  sel_code   =
      register_select[TSRS_SEL_LSB +: TSRS_SEL_W];
   wire logic        wr_select  = wr_byte_in.valid &&
                                  (wr_state == TSRS_WR_SELECT);
   wire logic        wr_high    = wr_byte_in.valid &&
                                  (wr_state == TSRS_WR_HIGH);
   wire logic        wr_commit  = wr_byte_in.valid &&
                                  (wr_state == TSRS_WR_LOW);
   wire logic [15:0] wr_word    = {high_byte, wr_byte_in.data};
   wire logic        wr_config  = wr_commit &&
                                  (sel_code == TSRS_SEL_CONFIG);
   wire logic        wr_upper   = wr_commit &&
                                  (sel_code == TSRS_SEL_UPPER);
   wire logic        wr_lower   = wr_commit &&
                                  (sel_code == TSRS_SEL_LOWER);
   wire logic        wr_crit    = wr_commit &&
                                  (sel_code == TSRS_SEL_CRIT);
   wire logic        conv_tick  = (conv_count == 32'(CONV_CYCLES - 1));

   // ==================================================================
   // Writable registers
   logic [15:0] config_word;
   logic [15:0] upper_word;
   logic [15:0] lower_word;
   logic [15:0] crit_word;

   tsrs_word_reg u_config (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .write_in  (wr_config),
      .data_in   (wr_word),
      .value_out (config_word)
   );

   tsrs_word_reg u_upper (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .write_in  (wr_upper),
      .data_in   (wr_word),
      .value_out (upper_word)
   );

   tsrs_word_reg u_lower (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .write_in  (wr_lower),
      .data_in   (wr_word),
      .value_out (lower_word)
   );

   tsrs_word_reg u_crit (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .write_in  (wr_crit),
      .data_in   (wr_word),
      .value_out (crit_word)
   );

   // ==================================================================
   // Read selection; the selection register itself is never a source
   logic [15:0] rd_word;
   always_comb begin
      case (sel_code)
         TSRS_SEL_CONFIG: rd_word = config_word;
         TSRS_SEL_UPPER:  rd_word = upper_word;
         TSRS_SEL_LOWER:  rd_word = lower_word;
         TSRS_SEL_CRIT:   rd_word = crit_word;
         TSRS_SEL_TEMP:   rd_word = temp_result;
         TSRS_SEL_MFR_ID: rd_word = MFR_ID;
         TSRS_SEL_DEV_ID: rd_word = DEV_ID;
         default:         rd_word = TSRS_WORD_RST;
      endcase
   end

   // Signed compare of the temperature fields
   wire logic signed [TSRS_TEMP_W-1:0] t_now   =
      temp_result[TSRS_TEMP_W-1:0];
   wire logic signed [TSRS_TEMP_W-1:0] t_upper =
      upper_word[TSRS_TEMP_W-1:0];
   wire logic signed [TSRS_TEMP_W-1:0] t_lower =
      lower_word[TSRS_TEMP_W-1:0];
   wire logic signed [TSRS_TEMP_W-1:0] t_crit  =
      crit_word[TSRS_TEMP_W-1:0];
   wire logic out_of_window = (t_now > t_upper) || (t_now < t_lower);
   wire logic alert_enable  = config_word[TSRS_ALERT_EN_BIT];

   // ==================================================================
   // Write phase sequencing; extra bytes are ignored
   always_comb begin
      next_wr_state = wr_state;
      if (xfer_start_in) begin
         next_wr_state = TSRS_WR_SELECT;
      end else if (wr_byte_in.valid) begin
         case (wr_state)
            TSRS_WR_SELECT: next_wr_state = TSRS_WR_HIGH;
            TSRS_WR_HIGH:   next_wr_state = TSRS_WR_LOW;
            TSRS_WR_LOW:    next_wr_state = TSRS_WR_DONE;
            default:        next_wr_state = TSRS_WR_DONE;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_state <= TSRS_WR_DONE;
      end else begin
         wr_state <= next_wr_state;
      end
   end

   // Register selection, held across transactions
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         register_select <= TSRS_SELECT_RST;
      end else if (wr_select) begin
         register_select <= wr_byte_in.data;
      end
   end

   // High byte holding until the low byte completes the word
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_byte <= 8'h00;
      end else if (wr_high) begin
         high_byte <= wr_byte_in.data;
      end
   end

   // ==================================================================
   // Read bytes, high then low, restarting each transaction
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_low       <= 1'b0;
         rd_data_out  <= 8'h00;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_req_in;
         if (xfer_start_in) begin
            rd_low <= 1'b0;
         end else if (rd_req_in) begin
            rd_low      <= ~rd_low;
            rd_data_out <= rd_low ? rd_word[7:0] : rd_word[15:8];
         end
      end
   end

   // ==================================================================
   // Conversion period timer
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         conv_count <= 32'h0000_0000;
      end else if (conv_tick) begin
         conv_count <= 32'h0000_0000;
      end else begin
         conv_count <= conv_count + 32'h0000_0001;
      end
   end

   // Shadow catches samples; readable copy loads once per period
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         temp_shadow <= TSRS_WORD_RST;
         temp_result <= TSRS_WORD_RST;
         update_out  <= 1'b0;
      end else begin
         update_out <= conv_tick;
         if (sample_valid_in) begin
            temp_shadow <= sample_in;
         end
         if (conv_tick) begin
            temp_result <= temp_shadow;
         end
      end
   end

   // ==================================================================
   // Threshold outputs
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alert_out <= 1'b0;
         crit_out  <= 1'b0;
      end else begin
         alert_out <= alert_enable && out_of_window;
         crit_out  <= (t_now > t_crit);
      end
   end

   // Reads use the last written selection; the direction flag is not needed
   wire logic unused_ok = xfer_read_in;

endmodule : tsrs_bank

`default_nettype wire

// [inc/tsrs_pkg.sv]
// Shared constants and types for the temperature sensor register bank
package tsrs_pkg;

   // ==================================================================
   // Register selection codes, low four bits of register_select
   localparam logic [3:0] TSRS_SEL_RESERVED = 4'h0;
   localparam logic [3:0] TSRS_SEL_CONFIG   = 4'h1;
   localparam logic [3:0] TSRS_SEL_UPPER    = 4'h2;
   localparam logic [3:0] TSRS_SEL_LOWER    = 4'h3;
   localparam logic [3:0] TSRS_SEL_CRIT     = 4'h4;
   localparam logic [3:0] TSRS_SEL_TEMP     = 4'h5;
   localparam logic [3:0] TSRS_SEL_MFR_ID   = 4'h6;
   localparam logic [3:0] TSRS_SEL_DEV_ID   = 4'h7;

   // ==================================================================
   // Field positions and widths
   localparam int         TSRS_SEL_LSB      = 0;
   localparam int         TSRS_SEL_W        = 4;
   localparam int         TSRS_TEMP_W       = 13;
   localparam int         TSRS_ALERT_EN_BIT = 3;

   // ==================================================================
   // Values after reset
   localparam logic [7:0]  TSRS_SELECT_RST = 8'h00;
   localparam logic [15:0] TSRS_WORD_RST   = 16'h0000;

   // ==================================================================
   // Conversion period timing, 40 MHz clock
   localparam int TSRS_CLK_HZ         = 40000000;
   localparam int TSRS_CONV_PERIOD_MS = 250;
   localparam int TSRS_CONV_CYCLES    =
      (TSRS_CLK_HZ / 1000) * TSRS_CONV_PERIOD_MS;

   // ==================================================================
   // One byte handed over by the serial front end
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } tsrs_byte_t;

   // Write phase of a write transaction
   typedef enum logic [1:0] {
      TSRS_WR_SELECT,
      TSRS_WR_HIGH,
      TSRS_WR_LOW,
      TSRS_WR_DONE
   } tsrs_wr_state_t;

endpackage : tsrs_pkg

// [logic/tsrs_word_reg.sv]
// Read/write 16-bit register loaded from a two-byte write
`timescale 1ns/10ps
`default_nettype none

module tsrs_word_reg
   import tsrs_pkg::*;
#(
   parameter logic [15:0] RESET_VALUE = TSRS_WORD_RST
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   // Write port
   input  wire logic        write_in,
   input  wire logic [15:0] data_in,
   // Stored value
   output logic      [15:0] value_out
);

   // ==================================================================
   // Storage
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         value_out <= RESET_VALUE;
      end else if (write_in) begin
         value_out <= data_in;
      end
   end

endmodule : tsrs_word_reg

`default_nettype wire

// [tb/tsrs_bank_props.sv]
// Port checker for the sensor register bank
`timescale 1ns/10ps
`default_nettype none

module tsrs_bank_props
   import tsrs_pkg::*;
#(
   parameter int CONV_CYCLES = TSRS_CONV_CYCLES
) (
   // Bank ports, all observed
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        xfer_start_in,
   input wire logic        xfer_read_in,
   input wire tsrs_byte_t  wr_byte_in,
   input wire logic        rd_req_in,
   input wire logic [7:0]  rd_data_out,
   input wire logic        rd_valid_out,
   input wire logic        sample_valid_in,
   input wire logic [15:0] sample_in,
   input wire logic        alert_out,
   input wire logic        crit_out,
   input wire logic        update_out
);
   int         gap;
   logic       seen;
   logic [2:0] upd_h;
   logic [2:0] wr_h;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   // Reload spacing and recent causes of threshold changes
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gap   <= 0;
         seen  <= 1'b0;
         upd_h <= 3'h0;
         wr_h  <= 3'h0;
      end else begin
         gap   <= update_out ? 1 : gap + 1;
         seen  <= seen | update_out;
         upd_h <= {upd_h[1:0], update_out};
         wr_h  <= {wr_h[1:0], wr_byte_in.valid};
      end
   end

   // ==============================
   // Properties
   property p_rd_answer; rd_req_in |=> rd_valid_out; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered");
   property p_rd_cause; rd_valid_out |-> $past(rd_req_in); endproperty
   a_rd_cause: assert property (p_rd_cause)
      else $error("read byte without request");
   property p_rd_hold; !rd_req_in |=> $stable(rd_data_out); endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved");
   property p_upd_period; update_out && seen |-> gap == CONV_CYCLES;
   endproperty
   a_upd_period: assert property (p_upd_period)
      else $error("reload spacing wrong");
   property p_upd_single; update_out |=> !update_out [*8]; endproperty
   a_upd_single: assert property (p_upd_single)
      else $error("reload pulse too long");
   property p_alert_cause;
      $changed(alert_out) |-> update_out || (|upd_h) || (|wr_h);
   endproperty
   a_alert_cause: assert property (p_alert_cause)
      else $error("alert moved without cause");
   property p_crit_cause;
      $changed(crit_out) |-> update_out || (|upd_h) || (|wr_h);
   endproperty
   a_crit_cause: assert property (p_crit_cause)
      else $error("critical moved without cause");
   property p_reset_quiet; !$past(rst_n_in) |->
      !alert_out && !crit_out && !update_out && !rd_valid_out;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active after reset");
endmodule : tsrs_bank_props

bind tsrs_bank tsrs_bank_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (
   .clock_in(clock_in), .rst_n_in(rst_n_in),
   .xfer_start_in(xfer_start_in), .xfer_read_in(xfer_read_in),
   .wr_byte_in(wr_byte_in), .rd_req_in(rd_req_in),
   .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
   .sample_valid_in(sample_valid_in), .sample_in(sample_in),
   .alert_out(alert_out), .crit_out(crit_out), .update_out(update_out)
);
`default_nettype wire

// [tb/tsrs_master.sv]
// Bus master model that frames writes and reads
`timescale 1ns/10ps
`default_nettype none

module tsrs_master
   import tsrs_pkg::*;
(
   // Clock
   input  wire logic       clock_in,
   // Requests
   output logic            xfer_start_out,
   output logic            xfer_read_out,
   output var tsrs_byte_t  wr_byte_out,
   output logic            rd_req_out,
   // Answers
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in
);
   // Idle bus at time zero
   initial begin
      xfer_start_out = 1'b0;
      xfer_read_out  = 1'b0;
      wr_byte_out    = '{valid: 1'b0, data: 8'h00};
      rd_req_out     = 1'b0;
   end

   // One-cycle transaction start
   task automatic frame(input logic rd);
      @(posedge clock_in);
      #1 xfer_start_out = 1'b1;
      xfer_read_out = rd;
      @(posedge clock_in);
      #1 xfer_start_out = 1'b0;
   endtask : frame

   // Selection byte, then optionally the word; data scrambled after
   task automatic put(input logic [7:0] sel, input logic [15:0] w,
                      input bit full);
      logic [7:0] b [3];
      b = '{sel, w[15:8], w[7:0]};
      frame(1'b0);
      for (int i = 0; i < (full ? 3 : 1); i++) begin
         wr_byte_out = '{valid: 1'b1, data: b[i]};
         @(posedge clock_in);
         #1;
      end
      wr_byte_out = '{valid: 1'b0, data: ~wr_byte_out.data};
   endtask : put

   // Four bytes in one read frame, missing answers read unknown
   task automatic get(output logic [31:0] w);
      frame(1'b1);
      for (int i = 3; i >= 0; i--) begin
         rd_req_out = 1'b1;
         @(posedge clock_in);
         #1 w[i*8 +: 8] = (rd_valid_in === 1'b1) ? rd_data_in : 8'hXX;
      end
      rd_req_out = 1'b0;
   endtask : get
endmodule : tsrs_master
`default_nettype wire

// [tb/tsrs_bank_tb.sv]
// Self-checking bench for the sensor register bank
`timescale 1ns/10ps
`default_nettype none

module tsrs_bank_tb
   import tsrs_pkg::*;
;
   // Short period; identification values are arbitrary
   localparam int          CONV = 20;
   localparam logic [15:0] MFR  = 16'h3C1E;
   localparam logic [15:0] DEV  = 16'h1E3C;

   logic        clock_in = 1'b0;
   logic        rst_n_in, start, rd, rq, rv, sv, alert, crit, update;
   logic [7:0]  rdat;
   logic [15:0] smp;
   tsrs_byte_t  wb;
   int          fail_count = 0;
   int          check_count = 0;
   logic [15:0] vals [1:4] = '{16'h0008, 16'h0100, 16'h1F00, 16'h0300};

   always #12.5 clock_in = ~clock_in;

   tsrs_bank #(.CONV_CYCLES(CONV), .MFR_ID(MFR), .DEV_ID(DEV)) dut_u (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .xfer_start_in(start),
      .xfer_read_in(rd), .wr_byte_in(wb), .rd_req_in(rq),
      .rd_data_out(rdat), .rd_valid_out(rv), .sample_valid_in(sv),
      .sample_in(smp), .alert_out(alert), .crit_out(crit),
      .update_out(update));

   tsrs_master master_u (
      .clock_in(clock_in), .xfer_start_out(start), .xfer_read_out(rd),
      .wr_byte_out(wb), .rd_req_out(rq), .rd_data_in(rdat),
      .rd_valid_in(rv));

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Wait for a reload pulse, then hand the converter a new sample
   task automatic upd(input logic [15:0] s);
      int n = 0;
      while (update !== 1'b1 && n < 3 * CONV) begin
         @(posedge clock_in);
         #1 n++;
      end
      check(update, 1'b1);
      repeat (2) @(posedge clock_in);
      #1 smp = s;
      sv = 1'b1;
      @(posedge clock_in);
      #1 sv = 1'b0;
   endtask : upd

   // Verdict and end of run
   task automatic end_sim();
      $display("Checks %0d, errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   // Watchdog, well beyond the expected few hundred cycles
   initial begin
      #(25 * 4000);
      fail_count++;
      end_sim();
   end

   // Main sequence
   initial begin
      logic [31:0] w;
      sv       = 1'b0;
      smp      = 16'h0000;
      rst_n_in = 1'b0;
      repeat (2) @(posedge clock_in);
      #1 rst_n_in = 1'b1;
      master_u.get(w);
      check(w, 32'h0);
      foreach (vals[c]) begin
         master_u.put(8'(c), vals[c], 1'b1);
      end
      foreach (vals[c]) begin
         master_u.put(8'(c), 16'h0000, 1'b0);
         master_u.get(w);
         check(w, {2{vals[c]}});
      end
      master_u.put({4'h0, TSRS_SEL_MFR_ID}, 16'hFFFF, 1'b1);
      master_u.get(w);
      check(w, {2{MFR}});
      master_u.get(w);
      check(w, {2{MFR}});
      master_u.put({4'h0, TSRS_SEL_DEV_ID}, 16'h0000, 1'b0);
      master_u.get(w);
      check(w, {2{DEV}});
      master_u.put(8'hF2, 16'h0000, 1'b0);
      master_u.get(w);
      check(w, {2{vals[2]}});
      master_u.put(8'h0A, 16'h0000, 1'b0);
      master_u.get(w);
      check(w, 32'h0);
      // Temperature reloads, write protection and thresholds
      upd(16'h0200);
      upd(16'h0400);
      check({alert, crit}, 2'b10);
      master_u.put({4'h0, TSRS_SEL_TEMP}, 16'h0777, 1'b1);
      master_u.get(w);
      check(w, {2{16'h0200}});
      upd(16'h0000);
      check({alert, crit}, 2'b11);
      master_u.get(w);
      check(w, {2{16'h0400}});
      // Alert enable off, then the lower edge of the window
      master_u.put({4'h0, TSRS_SEL_CONFIG}, 16'h0000, 1'b1);
      @(posedge clock_in);
      #1 check(alert, 1'b0);
      master_u.put({4'h0, TSRS_SEL_LOWER}, 16'h0080, 1'b1);
      master_u.put({4'h0, TSRS_SEL_CONFIG}, 16'h0008, 1'b1);
      upd(16'h0000);
      check({alert, crit}, 2'b10);
      // Mid-run reset must drop the identification selection
      master_u.put({4'h0, TSRS_SEL_MFR_ID}, 16'h0000, 1'b0);
      rst_n_in = 1'b0;
      repeat (2) @(posedge clock_in);
      #1 rst_n_in = 1'b1;
      master_u.get(w);
      check(w, 32'h0);
      end_sim();
   end
endmodule : tsrs_bank_tb
`default_nettype wire
